// ---- logic/sfc_host.sv ----
// Controller end: APB registers, frame sequencer with divided link clock, CRC generation and check.
//
// The APB interface to the registers and the register offsets were decided locally.
module sfc_host import sfc_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link
    sfc_link_if.host link
);
    typedef enum logic [4:0] {
        HS_IDLE = 5'b00001,
        HS_LEAD = 5'b00010,
        HS_HIGH = 5'b00100,
        HS_LOW = 5'b01000,
        HS_GAP = 5'b10000
    } sfc_hstate_type;

    sfc_hstate_type st_reg;
    sfc_hstate_type st_next;
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic [5:0] bit_reg;
    logic [5:0] bit_next;
    logic [31:0] tx_reg;
    logic [31:0] tx_next;
    logic [31:0] rx_reg;
    logic [31:0] rx_next;
    logic [31:0] resp_reg;
    logic [31:0] resp_next;
    logic resp_ok_reg;
    logic resp_ok_next;
    logic sclk_reg;
    logic sclk_next;
    logic cs_reg;
    logic cs_next;
    logic mosi_reg;
    logic mosi_next;
    logic [3:0] seed_reg;
    logic [3:0] seed_next;
    logic [1:0] int_reg;
    logic [1:0] int_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic irq_reg;
    logic irq_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic miso_s1_reg;
    logic miso_s2_reg;

    logic wr;
    logic rd;
    logic half_end;
    logic [23:0] cmd_body;
    logic [1:0] ev;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= link.miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    always_comb begin
        wr = psel && penable && pready_reg && pwrite;
        rd = psel && penable && pready_reg && !pwrite;
        half_end = (div_reg == HALF_CYCLES - 3'h1);
        cmd_body = pwdata[31:8];
        st_next = st_reg;
        div_next = half_end ? 3'h0 : div_reg + 3'h1;
        bit_next = bit_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        resp_next = resp_reg;
        resp_ok_next = resp_ok_reg;
        sclk_next = sclk_reg;
        cs_next = cs_reg;
        mosi_next = mosi_reg;
        seed_next = seed_reg;
        mask_next = mask_reg;
        ev = 2'b00;
        unique case (st_reg)
            HS_IDLE: begin
                div_next = 3'h0;
                if (wr && paddr == REG_CMD) begin
                    tx_next = {cmd_body, crc8_frame(crc_seed(seed_reg), {cmd_body, 8'h00})};
                    mosi_next = cmd_body[23];
                    cs_next = 1'b0;
                    bit_next = 6'h00;
                    st_next = HS_LEAD;
                end
            end
            HS_LEAD: begin
                if (half_end) begin
                    sclk_next = 1'b1;
                    st_next = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (half_end) begin
                    rx_next = {rx_reg[30:0], miso_s2_reg};
                    tx_next = {tx_reg[30:0], 1'b0};
                    mosi_next = tx_reg[FRAME_BITS - 2];
                    sclk_next = 1'b0;
                    bit_next = bit_reg + 6'h01;
                    st_next = HS_LOW;
                end
            end
            HS_LOW: begin
                if (half_end) begin
                    if (bit_reg == FRAME_BITS_CNT) begin
                        cs_next = 1'b1;
                        mosi_next = 1'b0;
                        resp_next = rx_reg;
                        resp_ok_next = (crc8_frame(crc_seed(seed_reg), rx_reg) == 8'h00);
                        ev[INT_FRAME_DONE] = 1'b1;
                        ev[INT_RESP_CRC_ERR] = (crc8_frame(crc_seed(seed_reg), rx_reg) != 8'h00);
                        st_next = HS_GAP;
                    end else begin
                        sclk_next = 1'b1;
                        st_next = HS_HIGH;
                    end
                end
            end
            HS_GAP: begin
                if (half_end) begin
                    st_next = HS_IDLE;
                end
            end
            default: begin
                st_next = HS_IDLE;
            end
        endcase
        if (wr && paddr == REG_CTRL) begin
            seed_next = pwdata[3:0];
        end
        if (wr && paddr == REG_INT_MASK) begin
            mask_next = pwdata[1:0];
        end
        // Events win over the clearing read.
        int_next = ((rd && paddr == REG_INT_STAT) ? 2'b00 : int_reg) | ev;
        irq_next = |(int_next & mask_next);
        pready_next = psel && !penable;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (paddr)
                REG_CTRL: prdata_next = {28'h000_0000, seed_reg};
                REG_CMD: prdata_next = {tx_reg[31:8], 8'h00};
                REG_RESP: prdata_next = resp_reg;
                REG_STATUS: prdata_next = {30'h000_0000, resp_ok_reg, (st_reg != HS_IDLE)};
                REG_INT_STAT: prdata_next = {30'h000_0000, int_reg | ev};
                REG_INT_MASK: prdata_next = {30'h000_0000, mask_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= HS_IDLE;
            div_reg <= 3'h0;
            bit_reg <= 6'h00;
            tx_reg <= 32'h0000_0000;
            rx_reg <= 32'h0000_0000;
            resp_reg <= 32'h0000_0000;
            resp_ok_reg <= 1'b0;
            sclk_reg <= 1'b0;
            cs_reg <= 1'b1;
            mosi_reg <= 1'b0;
            seed_reg <= 4'h0;
            int_reg <= 2'b00;
            mask_reg <= 2'b00;
            irq_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            resp_reg <= resp_next;
            resp_ok_reg <= resp_ok_next;
            sclk_reg <= sclk_next;
            cs_reg <= cs_next;
            mosi_reg <= mosi_next;
            seed_reg <= seed_next;
            int_reg <= int_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_reg;
    assign link.mosi = mosi_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule

// ---- logic/sfc_pkg.sv ----
// Shared constants, types and CRC helpers of the sensor frame link.
package sfc_pkg;
    // Frame layout.
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
    localparam int CMD_HI = 31;
    localparam int CMD_LO = 28;
    localparam int CRC_HI = 7;
    localparam logic [1:0] ST_SPI_ERROR = 2'h3;
    localparam logic [1:0] SF_SPI_ERROR = 2'h3;
    // Reserved command codes.
    localparam logic [3:0] CMD_RSVD_0 = 4'h0;
    localparam logic [3:0] CMD_RSVD_2 = 4'h2;
    localparam logic [3:0] CMD_RSVD_4 = 4'h4;
    localparam logic [3:0] CMD_RSVD_6 = 4'h6;
    localparam logic [3:0] CMD_RSVD_A = 4'ha;
    localparam logic [3:0] CMD_RSVD_E = 4'he;
    // CRC x^8 + x^5 + x^3 + x^2 + x + 1 and seed selection.
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_SEED_FULL = 8'hff;
    localparam logic [3:0] CRC_SEED_HIGH = 4'hf;
    localparam logic [3:0] SEED_NIBBLE_ZERO = 4'h0;
    // Link timing.
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 80;
    localparam int HALF_CYCLES_INT = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] HALF_CYCLES = HALF_CYCLES_INT[2:0];
    // Controller register offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_RESP = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_MASK = 8'h14;
    localparam int INT_FRAME_DONE = 0;
    localparam int INT_RESP_CRC_ERR = 1;

    typedef enum logic [2:0] {
        KIND_ERROR = 3'b001,
        KIND_DATA = 3'b010,
        KIND_RSVD = 3'b100
    } sfc_kind_type;

    function automatic logic [7:0] crc_seed(input logic [3:0] nibble);
        crc_seed = (nibble == SEED_NIBBLE_ZERO) ? CRC_SEED_FULL : {CRC_SEED_HIGH, nibble};
    endfunction

    // Non-direct serial CRC: bits rotate into the LSB, MSB first.
    function automatic logic [7:0] crc8_frame(input logic [7:0] seed, input logic [31:0] frame);
        logic [7:0] c;
        c = seed;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            c = {c[6:0], frame[i]} ^ (c[7] ? CRC_POLY : 8'h00);
        end
        crc8_frame = c;
    endfunction

    function automatic logic is_reserved(input logic [3:0] cmd);
        is_reserved = (cmd == CMD_RSVD_0) || (cmd == CMD_RSVD_2) || (cmd == CMD_RSVD_4) ||
            (cmd == CMD_RSVD_6) || (cmd == CMD_RSVD_A) || (cmd == CMD_RSVD_E);
    endfunction
endpackage

// ---- logic/sfc_link_if.sv ----
// Four-wire link between the controller end and the sensor end.
interface sfc_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport device (
        input sclk,
        input cs_n,
        input mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso,
        input miso_oe
    );
endinterface

// ---- logic/sfc_device.sv ----
// Sensor end: command CRC check, decode and CRC-protected response framing.
module sfc_device import sfc_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    sfc_link_if.device link,
    // Sensor state
    input wire logic [15:0] sensor_sample,
    input wire logic sample16_en,
    input wire logic [1:0] basic_status_code,
    input wire logic [1:0] detailed_status_code,
    input wire logic [3:0] crc_seed_nibble,
    // Command report
    output logic cmd_done,
    output logic cmd_crc_err,
    output logic cmd_reserved,
    output logic [2:0] cmd_source_selector
);
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_q_reg;
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_q_reg;
    logic mosi_s1_reg;
    logic mosi_s2_reg;

    logic [31:0] rx_reg;
    logic [31:0] rx_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [31:0] tx_reg;
    logic [31:0] tx_next;
    logic miso_reg;
    logic miso_next;
    logic oe_reg;
    logic oe_next;
    sfc_kind_type kind_reg;
    sfc_kind_type kind_next;
    logic [3:0] cmd_reg;
    logic [3:0] cmd_next;
    logic [1:0] st_cap_reg;
    logic [1:0] st_cap_next;
    logic [1:0] sf_cap_reg;
    logic [1:0] sf_cap_next;
    logic done_reg;
    logic done_next;
    logic crc_err_reg;
    logic crc_err_next;
    logic rsvd_reg;
    logic rsvd_next;
    logic [2:0] src_reg;
    logic [2:0] src_next;

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] seed;
    logic frame_bad;
    logic [3:0] rx_cmd;
    logic [23:0] body;
    logic [31:0] resp;

    // Link pins come from another clock domain.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_q_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_q_reg <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= link.sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_q_reg <= sclk_s2_reg;
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_q_reg <= cs_s2_reg;
            mosi_s1_reg <= link.mosi;
            mosi_s2_reg <= mosi_s1_reg;
        end
    end

    always_comb begin
        cs_fall = cs_q_reg && !cs_s2_reg;
        cs_rise = !cs_q_reg && cs_s2_reg;
        sclk_rise = !sclk_q_reg && sclk_s2_reg && !cs_s2_reg;
        sclk_fall = sclk_q_reg && !sclk_s2_reg && !cs_s2_reg;
        seed = crc_seed(crc_seed_nibble);
        frame_bad = (cnt_reg != FRAME_BITS_CNT) || (crc8_frame(seed, rx_reg) != 8'h00);
        rx_cmd = rx_reg[CMD_HI:CMD_LO];
        body = 24'h00_0000;
        unique case (kind_reg)
            KIND_DATA: begin
                body = {cmd_reg[3:1], 1'b1, st_cap_reg, sensor_sample[15:4],
                    (sample16_en ? sensor_sample[3:0] : 4'h0), sf_cap_reg};
            end
            KIND_RSVD: begin
                body = {cmd_reg, 20'h0_0000};
            end
            KIND_ERROR: begin
                body = {4'h0, ST_SPI_ERROR, 16'h0000, SF_SPI_ERROR};
            end
        endcase
        resp = {body, crc8_frame(seed, {body, 8'h00})};
    end

    always_comb begin
        rx_next = rx_reg;
        cnt_next = cnt_reg;
        tx_next = tx_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        kind_next = kind_reg;
        cmd_next = cmd_reg;
        st_cap_next = st_cap_reg;
        sf_cap_next = sf_cap_reg;
        done_next = 1'b0;
        crc_err_next = 1'b0;
        rsvd_next = 1'b0;
        src_next = src_reg;
        if (cs_fall) begin
            tx_next = resp;
            miso_next = resp[FRAME_BITS - 1];
            oe_next = 1'b1;
            cnt_next = 6'h00;
        end else if (cs_rise) begin
            oe_next = 1'b0;
            st_cap_next = basic_status_code;
            sf_cap_next = detailed_status_code;
            cmd_next = rx_cmd;
            if (frame_bad) begin
                kind_next = KIND_ERROR;
                crc_err_next = 1'b1;
            end else if (rx_cmd[0]) begin
                kind_next = KIND_DATA;
                done_next = 1'b1;
                src_next = rx_cmd[3:1];
            end else begin
                kind_next = KIND_RSVD;
                rsvd_next = is_reserved(rx_cmd);
            end
        end else begin
            if (sclk_rise) begin
                rx_next = {rx_reg[30:0], mosi_s2_reg};
                if (cnt_reg != 6'h3f) begin
                    cnt_next = cnt_reg + 6'h01;
                end
            end
            if (sclk_fall) begin
                tx_next = {tx_reg[30:0], 1'b0};
                miso_next = tx_reg[FRAME_BITS - 2];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_reg <= 32'h0000_0000;
            cnt_reg <= 6'h00;
            tx_reg <= 32'h0000_0000;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            kind_reg <= KIND_ERROR;
            cmd_reg <= 4'h0;
            st_cap_reg <= 2'h0;
            sf_cap_reg <= 2'h0;
            done_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            rsvd_reg <= 1'b0;
            src_reg <= 3'h0;
        end else begin
            rx_reg <= rx_next;
            cnt_reg <= cnt_next;
            tx_reg <= tx_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            kind_reg <= kind_next;
            cmd_reg <= cmd_next;
            st_cap_reg <= st_cap_next;
            sf_cap_reg <= sf_cap_next;
            done_reg <= done_next;
            crc_err_reg <= crc_err_next;
            rsvd_reg <= rsvd_next;
            src_reg <= src_next;
        end
    end

    assign link.miso = miso_reg;
    assign link.miso_oe = oe_reg;
    assign cmd_done = done_reg;
    assign cmd_crc_err = crc_err_reg;
    assign cmd_reserved = rsvd_reg;
    assign cmd_source_selector = src_reg;
endmodule

// ---- dv/sfc_link_monitor.sv ----
// Wire-level assertions for the sensor frame link.
module sfc_link_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic sclk_reg;
    logic sclk_next;
    logic [5:0] rise_cnt_reg;
    logic [5:0] rise_cnt_next;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Counts link clock rises inside the current frame.
    always_comb begin
        sclk_next = sclk;
        rise_cnt_next = cs_n ? 6'h00 : rise_cnt_reg + {5'h00, sclk && !sclk_reg};
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sclk_reg <= 1'b0;
            rise_cnt_reg <= 6'h00;
        end else begin
            sclk_reg <= sclk_next;
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    idle_clock_low_a:
        assert property (cs_n |-> !sclk) else $error("clock moved while deselected");
    first_rise_a:
        assert property ($fell(cs_n) |-> !sclk [*5] ##1 sclk) else $error("first rise misplaced");
    high_phase_a:
        assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk) else $error("high phase wrong");
    low_phase_a:
        assert property ($fell(sclk) |-> !sclk [*5]) else $error("low phase short");
    bit_count_a:
        assert property ($rose(cs_n) |-> rise_cnt_reg == 6'h20) else $error("frame not 32 clocks");
    mosi_on_fall_a:
        assert property (!cs_n && !$past(cs_n) && $changed(mosi) |-> $fell(sclk)) else $error("mosi moved off fall");
    miso_steady_a:
        assert property (sclk && $past(sclk) |-> $stable(miso)) else $error("miso moved while high");
    drive_on_a:
        assert property ($fell(cs_n) |-> ##[1:6] miso_oe) else $error("miso not driven");
    drive_off_a:
        assert property ($rose(cs_n) |-> ##[0:6] !miso_oe) else $error("miso not released");
    frame_gap_a:
        assert property ($rose(cs_n) |-> cs_n [*5]) else $error("select gap short");

    cover property ($rose(cs_n));
    cover property ($fell(miso_oe));
    cover property (rise_cnt_reg == 6'h20);
endmodule

// ---- dv/spi_frame_crc_response_bench.sv ----
// Bench joining the controller end and the sensor end over the link.
module spi_frame_crc_response_bench import sfc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [15:0] smp = 16'h0000;
    logic wide = 1'b0;
    logic [1:0] bst = 2'h0;
    logic [1:0] dst = 2'h0;
    logic [3:0] dseed = 4'h0;
    logic cmd_done;
    logic cmd_crc_err;
    logic cmd_reserved;
    logic [2:0] sel;
    logic sclk_d = 1'b0;
    logic cs_d = 1'b1;
    logic last_err;
    logic [31:0] mosi_sh, miso_sh, mosi_frame, miso_frame;
    logic [3:0] prev_cmd = 4'h0;
    logic prev_good = 1'b0;
    logic [1:0] prev_bst = 2'h0;
    logic [1:0] prev_dst = 2'h0;
    logic [1:0] irq_mask = 2'h0;
    logic [3:0] rsvd_codes [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he};
    int err_count = 0;
    int comparisons = 0;
    int n_done = 0;
    int n_bad = 0;
    int n_rsvd = 0;

    sfc_link_if u_sfc_link_if ();
    wire sclk = u_sfc_link_if.sclk;
    wire cs_n = u_sfc_link_if.cs_n;

    sfc_host u_sfc_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link(u_sfc_link_if.host));
    sfc_device u_sfc_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(u_sfc_link_if.device),
        .sensor_sample(smp), .sample16_en(wide), .basic_status_code(bst), .detailed_status_code(dst),
        .crc_seed_nibble(dseed), .cmd_done(cmd_done), .cmd_crc_err(cmd_crc_err), .cmd_reserved(cmd_reserved),
        .cmd_source_selector(sel));
    sfc_link_monitor u_sfc_link_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .mosi(u_sfc_link_if.mosi), .miso(u_sfc_link_if.miso), .miso_oe(u_sfc_link_if.miso_oe));

    initial begin
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    // Shifts each wire bit at the edge where its receiver samples it.
    always @(posedge ref_clk) begin
        sclk_d <= sclk;
        cs_d <= cs_n;
        if (!cs_n && sclk && !sclk_d) mosi_sh <= {mosi_sh[30:0], u_sfc_link_if.mosi};
        if (!cs_n && !sclk && sclk_d) miso_sh <= {miso_sh[30:0], u_sfc_link_if.miso};
        if (cs_n && !cs_d) begin
            mosi_frame <= mosi_sh;
            miso_frame <= miso_sh;
        end
        if (cmd_done === 1'b1) n_done <= n_done + 1;
        if (cmd_crc_err === 1'b1) n_bad <= n_bad + 1;
        if (cmd_reserved === 1'b1) n_rsvd <= n_rsvd + 1;
    end

    function automatic logic [7:0] crc_ref(input logic [3:0] nib, input logic [23:0] msg);
        logic [7:0] c;
        logic [31:0] f;
        c = (nib == 4'h0) ? 8'hff : {4'hf, nib};
        f = {msg, 8'h00};
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], f[i]} ^ (c[7] ? 8'h2f : 8'h00);
        end
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the watchdog ends a transfer that never gets pready.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        check(q, want);
    endtask

    // Sends one command and checks the reply that carries the previous one.
    task automatic frame(input logic [3:0] cmd, input logic [3:0] hs, input logic [3:0] ds);
        logic [31:0] x;
        logic [31:0] body;
        logic [31:0] resp;
        logic [15:0] s;
        logic good;
        logic rok;
        int d0;
        int b0;
        int r0;
        int n;
        d0 = n_done;
        b0 = n_bad;
        r0 = n_rsvd;
        s = {cmd, ~cmd, cmd ^ 4'h9, 4'h6};
        dseed <= ds;
        smp <= s;
        bst <= cmd[1:0];
        dst <= cmd[3:2];
        wr(REG_CTRL, {28'h000_0000, hs});
        if (!prev_good) body = 32'h0c00_0300;
        else if (prev_cmd[0]) body = {prev_cmd, prev_bst, s[15:4], wide ? s[3:0] : 4'h0, prev_dst, 8'h00};
        else body = {prev_cmd, 28'h000_0000};
        resp = {body[31:8], crc_ref(ds, body[31:8])};
        good = crc_ref(hs, {cmd, 20'h0_0000}) == crc_ref(ds, {cmd, 20'h0_0000});
        rok = crc_ref(hs, body[31:8]) == resp[7:0];
        wr(REG_CMD, {cmd, 28'h000_0000});
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0000_0000, x);
            n++;
        end while (x[0] !== 1'b0 && n < 500);
        check(mosi_frame, {cmd, 20'h0_0000, crc_ref(hs, {cmd, 20'h0_0000})});
        check(miso_frame, resp);
        rd(REG_RESP, resp);
        check(x, {30'h000_0000, rok, 1'b0});
        check(irq, (irq_mask & {~rok, 1'b1}) != 2'h0);
        rd(REG_INT_STAT, {30'h000_0000, ~rok, 1'b1});
        rd(REG_INT_STAT, 32'h0000_0000);
        check(irq, 1'b0);
        check(n_done - d0, good && cmd[0]);
        check(n_bad - b0, !good);
        check(n_rsvd - r0, good && (cmd inside {rsvd_codes}));
        if (good && cmd[0]) check(sel, cmd[3:1]);
        prev_cmd = cmd;
        prev_good = good;
        prev_bst = cmd[1:0];
        prev_dst = cmd[3:2];
        $display("frame %h checked", cmd);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h18, 32'h0000_0000);
        check(last_err, 1'b1);
        rd(REG_STATUS, 32'h0000_0000);
        rd(REG_INT_STAT, 32'h0000_0000);
        rd(REG_INT_MASK, 32'h0000_0000);
        $display("reset checks done");
        frame(4'h3, 4'h0, 4'h0);
        frame(4'h0, 4'h0, 4'h0);
        foreach (rsvd_codes[i]) frame(rsvd_codes[i], 4'h0, 4'h0);
        wr(REG_INT_MASK, 32'h0000_0003);
        irq_mask = 2'h3;
        wide <= 1'b1;
        frame(4'hf, 4'h5, 4'h5);
        frame(4'h8, 4'h5, 4'h5);
        frame(4'h1, 4'h3, 4'h5);
        frame(4'h9, 4'h0, 4'h0);
        frame(4'h1, 4'h0, 4'h0);
        give_verdict();
    end

    initial begin
        #200_000;
        err_count++;
        give_verdict();
    end
endmodule
